// ==== dv/dcc_channel_tb.sv ====
`timescale 1ns/1ps
// ****
// Testbench
// ****
module dcc_channel_tb;
	logic               mclk_i = 1'b0;
	logic               resetn_i = 1'b0;
	logic [3:0]         reg_addr_i = 4'h0;
	logic [15:0]        reg_wdata_i = 16'h0000;
	logic               reg_wr_i = 1'b0;
	logic               reg_rd_i = 1'b0;
	logic               req_en = 1'b0;
	logic               stall = 1'b0;
	logic [15:0]        reg_rdata_o;
	logic [15:0]        src_data_i;
	logic               req_i;
	logic               xfer_valid_o;
	logic               xfer_ready_i;
	logic               active_o;
	logic               block_done_o;
	dcc_pkg::dcc_xfer_t xfer_o;
	dcc_pkg::dcc_xfer_t got_q[$];
	int                 error_cnt = 0;
	int                 checked = 0;
	int                 sent = 0;
	int                 done_cnt = 0;
	logic [15:0]        d;
	always #5 mclk_i = ~mclk_i;
	dcc_channel #(.CNT_W(16)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .req_i(req_i), .src_data_i(src_data_i),
		.xfer_valid_o(xfer_valid_o), .xfer_ready_i(xfer_ready_i), .xfer_o(xfer_o),
		.active_o(active_o), .block_done_o(block_done_o));
	dcc_periph u_periph (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_en_i(req_en),
		.stall_i(stall), .req_o(req_i), .data_o(src_data_i), .ready_o(xfer_ready_i));
	// Inputs move only at rising edges, so the falling edge sees the coming handshake
	always @(negedge mclk_i) if (xfer_valid_o === 1'b1 && xfer_ready_i === 1'b1) begin
		got_q.push_back(xfer_o);
	end
	always @(negedge mclk_i) if (block_done_o === 1'b1) begin
		done_cnt++;
	end
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask : rd
	task automatic req(input int n);
		@(posedge mclk_i);
		req_en <= 1'b1;
		repeat (n) @(posedge mclk_i);
		req_en <= 1'b0;
		sent += n;
		repeat (8) @(posedge mclk_i);
	endtask : req
	function automatic logic [33:0] exp_x(int k, logic sz, logic dir, logic [15:0] ad);
		logic [15:0] v;
		v = 16'h1201 + 16'(k) * 16'h0101;
		return {sz ? {8'h00, v[7:0]} : v, sz, dir, ad};
	endfunction : exp_x
	task automatic t_regs;
		rd(4'h0, d); chk(d, 16'h0000);
		rd(4'hf, d); chk(d, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			wr(4'h0, 16'(m)); rd(4'h0, d); chk(d, 16'(m));
		end
		wr(4'h0, 16'h7ff7); rd(4'h0, d); chk(d, 16'h7833);
		wr(4'h0, 16'h0000);
		$display("test regs done");
	endtask : t_regs
	task automatic t_fields;
		logic [1:0] am;
		int k0;
		wr(4'h2, 16'h0100); wr(4'h3, 16'h0200); wr(4'h4, 16'h0003);
		rd(4'h2, d); chk(d, 16'h0100); rd(4'h3, d); chk(d, 16'h0200);
		for (int i = 0; i < 8; i++) begin
			am = 2'(i); k0 = sent; got_q.delete();
			wr(4'h0, 16'h8000 | 16'(i[2]) << 14 | 16'(i[0]) << 13 | 16'(am) << 4);
			req(2); wr(4'h0, 16'h0000);
			chk(got_q.size(), am == 2'b11 ? 0 : 2);
			for (int j = 0; j < 2 && am != 2'b11; j++) chk(got_q[j], exp_x(k0 + j, i[2], i[0],
				am == 2'b10 ? 16'h0000 : 16'h0100 + 16'(am == 2'b00 ? j * (i[2] ? 1 : 2) : 0)));
		end
		$display("test fields done");
	endtask : t_fields
	task automatic t_modes;
		int k0;
		wr(4'h4, 16'h0000);
		for (int m = 1; m < 4; m++) begin
			got_q.delete(); k0 = sent; done_cnt = 0;
			wr(4'h0, 16'h8000 | 16'(m));
			repeat (3) req(1);
			chk(active_o, m == 2);
			chk(got_q.size(), m == 1 ? 1 : m == 2 ? 3 : 2);
			for (int j = 0; j < got_q.size(); j++) chk(got_q[j], exp_x(k0 + j, 1'b0, 1'b0,
				m > 1 && j[0] ? 16'h0200 : 16'h0100));
			chk(done_cnt, m == 1 ? 1 : m == 2 ? 3 : 2);
			rd(4'h1, d); chk(d, m == 2 ? 16'h0007 : 16'h0004);
			wr(4'h1, 16'h0004); rd(4'h1, d); chk(d, m == 2 ? 16'h0003 : 16'h0000);
			wr(4'h0, 16'h0000);
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_stall;
		int k0;
		wr(4'h4, 16'h0003); got_q.delete(); k0 = sent;
		stall <= 1'b1;
		wr(4'h0, 16'h8000); req(4);
		stall <= 1'b0;
		repeat (8) @(posedge mclk_i);
		chk(got_q.size(), 2);
		chk(got_q[1], exp_x(k0 + 1, 1'b0, 1'b0, 16'h0102));
		wr(4'h0, 16'h0000); got_q.delete(); req(2);
		chk(got_q.size(), 0);
		chk(active_o, 1'b0);
		$display("test stall done");
	endtask : t_stall
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (16) @(posedge mclk_i);
		resetn_i <= 1'b1;
		t_regs; t_fields; t_modes; t_stall;
		print_verdict;
	end
	initial begin
		#200000;
		error_cnt++;
		print_verdict;
	end
endmodule : dcc_channel_tb

// ==== dv/dcc_chk_properties.sv ====
`timescale 1ns/1ps
`include "dcc_consts.svh"
// ****
// Port checker
// ****
module dcc_chk #(
	parameter int CNT_W = 16
) (
	input wire logic               mclk_i,
	input wire logic               resetn_i,
	input wire logic [3:0]         reg_addr_i,
	input wire logic [15:0]        reg_wdata_i,
	input wire logic               reg_wr_i,
	input wire logic               reg_rd_i,
	input wire logic [15:0]        reg_rdata_o,
	input wire logic               req_i,
	input wire logic [15:0]        src_data_i,
	input wire logic               xfer_valid_o,
	input wire logic               xfer_ready_i,
	input wire dcc_pkg::dcc_xfer_t xfer_o,
	input wire logic               active_o,
	input wire logic               block_done_o
);
	logic [15:0] ctl_ff;
	logic [15:0] nxt_ctl;
	logic        wr0;
	assign wr0 = reg_wr_i && reg_addr_i == 4'h0;
	always_comb begin
		nxt_ctl = wr0 ? (reg_wdata_i & `DCC_CTRL_WMASK) : ctl_ff;
	end
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctl_ff <= 16'h0000;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	property p_on; wr0 && reg_wdata_i[15] && !ctl_ff[15] |=> ##1 active_o; endproperty
	property p_off; wr0 && !reg_wdata_i[15] |=> ##1 !active_o [*2]; endproperty
	property p_byte; xfer_valid_o && xfer_o.byte_sz |-> xfer_o.data[15:8] == 8'h00; endproperty
	property p_size; $rose(xfer_valid_o) |-> xfer_o.byte_sz == $past(ctl_ff[14]); endproperty
	property p_dir; $rose(xfer_valid_o) |-> xfer_o.to_periph == $past(ctl_ff[13]); endproperty
	property p_rsvd; $rose(xfer_valid_o) |-> $past(ctl_ff[5:4]) != 2'b11; endproperty
	property p_per; $rose(xfer_valid_o) && $past(ctl_ff[5:4]) == 2'b10 |-> xfer_o.addr == 16'h0000;
	endproperty
	property p_rd; reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o == $past(ctl_ff); endproperty
	property p_one; block_done_o && ctl_ff[1:0] == 2'b01 |-> ##[0:1] !active_o; endproperty
	property p_cont; block_done_o && ctl_ff[1:0] == 2'b10 |-> active_o; endproperty
	property p_hold; xfer_valid_o && !xfer_ready_i |=> xfer_valid_o && $stable(xfer_o); endproperty
	a_on: assert property (p_on) else $error("channel did not start");
	a_off: assert property (p_off) else $error("channel did not stop");
	a_byte: assert property (p_byte) else $error("byte element upper half not zero");
	a_size: assert property (p_size) else $error("element size flag wrong");
	a_dir: assert property (p_dir) else $error("direction flag wrong");
	a_rsvd: assert property (p_rsvd) else $error("transfer under reserved addressing");
	a_per: assert property (p_per) else $error("peripheral addressing drove an address");
	a_rd: assert property (p_rd) else $error("control readback wrong");
	a_one: assert property (p_one) else $error("one-shot kept running");
	a_cont: assert property (p_cont) else $error("continuous mode stopped");
	a_hold: assert property (p_hold) else $error("stream word changed while stalled");
	c_done: cover property (block_done_o);
	c_stall: cover property (xfer_valid_o && !xfer_ready_i);
	c_byte: cover property ($rose(xfer_valid_o) && xfer_o.byte_sz);
endmodule : dcc_chk

bind dcc_channel dcc_chk #(.CNT_W(CNT_W)) u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i), .src_data_i(src_data_i),
	.xfer_valid_o(xfer_valid_o), .xfer_ready_i(xfer_ready_i), .xfer_o(xfer_o),
	.active_o(active_o), .block_done_o(block_done_o));

// ==== dv/dcc_periph.sv ====
`timescale 1ns/1ps
// ****
// Peripheral side model
// ****
module dcc_periph (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        req_en_i,
	input  wire logic        stall_i,
	output logic             req_o,
	output logic      [15:0] data_o,
	output logic             ready_o
);
	logic [15:0] seq_ff;
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_o <= 1'b0;
			data_o <= 16'h0000;
			seq_ff <= 16'h1201;
			ready_o <= 1'b0;
		end else begin
			req_o <= req_en_i;
			// Outside a request the bus flips so a stale word never looks valid
			data_o <= req_en_i ? seq_ff : ~data_o;
			seq_ff <= req_en_i ? seq_ff + 16'h0101 : seq_ff;
			ready_o <= !stall_i;
		end
	end
endmodule : dcc_periph

// ==== rtl/dcc_channel.sv ====
// Overview of operation
// - Bit 14 picks element width: one moves bytes, zero moves 16-bit words.
// - Addressing field: 11 reserved, 10 peripheral indirect, 01 no post-increment.
// - Operating mode sits in control bits 1-0, software writable, zero at reset.
// - Mode 11 one-shot ping-pong, 10 continuous ping-pong, 01 one-shot plain.
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_channel #(
	parameter int CNT_W = 16
) (
	input  wire logic              mclk_i,
	input  wire logic              resetn_i,
	// Register port
	input  wire logic [3:0]        reg_addr_i,
	input  wire logic [15:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [15:0]       reg_rdata_o,
	// Transfer request from the peripheral side (same clock)
	input  wire logic              req_i,
	// Data read from source, one element per accepted request
	input  wire logic [15:0]       src_data_i,
	// Outgoing transfer stream
	output logic                   xfer_valid_o,
	input  wire logic              xfer_ready_i,
	output dcc_pkg::dcc_xfer_t     xfer_o,
	output logic                   active_o,
	output logic                   block_done_o
);

	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
		$error("dcc_channel: CNT_W must be 2..16");
	end

	// ******************************
	// Registers
	// ******************************
	logic [15:0]         ctrl_ff, nxt_ctrl;
	logic [15:0]         buf0_ff, nxt_buf0;
	logic [15:0]         buf1_ff, nxt_buf1;
	logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
	logic [15:0]         rdata_ff, nxt_rdata;

	logic                chan_on;
	logic                byte_sz;
	logic                to_periph;
	dcc_pkg::dcc_addressing_select_t  addressing_select;
	dcc_pkg::dcc_opmode_t opmode;

	always_comb begin
		chan_on   = ctrl_ff[`DCC_BIT_ON];
		byte_sz   = ctrl_ff[`DCC_BIT_SIZE];
		to_periph = ctrl_ff[`DCC_BIT_DIR];
		addressing_select     = dcc_pkg::dcc_addressing_select_t'(ctrl_ff[`DCC_ADDRESSING_SELECT_HI:`DCC_ADDRESSING_SELECT_LO]);
		opmode    = dcc_pkg::dcc_opmode_t'(ctrl_ff[`DCC_MODE_HI:`DCC_MODE_LO]);
	end

	// ******************************
	// Channel state machine
	// ******************************
	dcc_pkg::dcc_state_t state_ff, nxt_state;
	logic                pp_sel_ff, nxt_pp_sel;
	logic [CNT_W-1:0]    idx_ff, nxt_idx;
	logic [15:0]         addr_ff, nxt_addr;
	logic                done_ff, nxt_done;
	logic                pulse_ff, nxt_pulse;
	logic                skid_ready;
	logic                take;
	logic                last;
	logic                pingpong;
	logic                oneshot;
	dcc_pkg::dcc_xfer_t  push_word;

	function automatic logic [15:0] step_addr(input logic [15:0] a,
	                                          input dcc_pkg::dcc_addressing_select_t m,
	                                          input logic b);
		logic [15:0] inc;
		inc = b ? 16'h0001 : 16'h0002;
		case (m)
			dcc_pkg::DCC_AM_POSTINC: step_addr = a + inc;
			default:                step_addr = a;
		endcase
	endfunction : step_addr

	function automatic logic [15:0] base_of(input logic sel,
	                                        input logic [15:0] b0,
	                                        input logic [15:0] b1);
		base_of = sel ? b1 : b0;
	endfunction : base_of

	always_comb begin
		pingpong  = opmode[1];
		oneshot   = opmode[0];
		last      = (idx_ff == cnt_ff);
		// Reserved addressing mode never moves data, so a bad setup cannot scribble memory
		take      = (state_ff == dcc_pkg::DCC_ST_RUN) && chan_on && req_i && skid_ready
		            && (addressing_select != dcc_pkg::DCC_AM_RSVD);
		push_word.data      = byte_sz ? {8'h00, src_data_i[7:0]} : src_data_i;
		push_word.byte_sz   = byte_sz;
		push_word.to_periph = to_periph;
		push_word.addr      = (addressing_select == dcc_pkg::DCC_AM_PERIPH) ? 16'h0000 : addr_ff;
		nxt_state  = state_ff;
		nxt_pp_sel = pp_sel_ff;
		nxt_idx    = idx_ff;
		nxt_addr   = addr_ff;
		nxt_done   = done_ff;
		nxt_pulse  = 1'b0;
		case (state_ff)
			dcc_pkg::DCC_ST_IDLE: begin
				if (chan_on) begin
					nxt_state  = dcc_pkg::DCC_ST_RUN;
					nxt_pp_sel = 1'b0;
					nxt_idx    = '0;
					nxt_addr   = buf0_ff;
				end
			end
			dcc_pkg::DCC_ST_RUN: begin
				if (take) begin
					nxt_addr = step_addr(addr_ff, addressing_select, byte_sz);
					nxt_idx  = idx_ff + 1'b1;
					if (last) begin
						nxt_idx   = '0;
						nxt_pulse = 1'b1;
						nxt_done  = 1'b1;
						if (pingpong) begin
							nxt_pp_sel = ~pp_sel_ff;
							nxt_addr   = base_of(~pp_sel_ff, buf0_ff, buf1_ff);
							// One-shot ping-pong stops after both buffers are done
							if (oneshot && pp_sel_ff) begin
								nxt_state = dcc_pkg::DCC_ST_DONE;
							end
						end else begin
							nxt_addr = buf0_ff;
							if (oneshot) begin
								nxt_state = dcc_pkg::DCC_ST_DONE;
							end
						end
					end
				end
			end
			default: begin
				nxt_state = dcc_pkg::DCC_ST_DONE;
			end
		endcase
		// Clearing the enable aborts any block in flight
		if (!chan_on) begin
			nxt_state = dcc_pkg::DCC_ST_IDLE;
		end
		// Done is sticky; a completion in the same cycle as the clear wins
		if (reg_wr_i && reg_addr_i == `DCC_ADDR_STAT && reg_wdata_i[`DCC_ST_DONE]
		    && !nxt_pulse) begin
			nxt_done = 1'b0;
		end
	end

	// ******************************
	// Register access
	// ******************************
	logic [15:0] stat_word;

	always_comb begin
		stat_word = 16'h0000;
		stat_word[`DCC_ST_BUSY]      = (state_ff == dcc_pkg::DCC_ST_RUN);
		stat_word[`DCC_ST_PINGSEL]   = pp_sel_ff;
		stat_word[`DCC_ST_DONE]      = done_ff;
		stat_word[`DCC_ST_ADDRESSING_SELECT_ERR] = (addressing_select == dcc_pkg::DCC_AM_RSVD);
		nxt_ctrl  = ctrl_ff;
		nxt_buf0  = buf0_ff;
		nxt_buf1  = buf1_ff;
		nxt_cnt   = cnt_ff;
		nxt_rdata = 16'h0000;
		if (reg_wr_i) begin
			if (reg_addr_i == `DCC_ADDR_CTRL) begin
				nxt_ctrl = reg_wdata_i & `DCC_CTRL_WMASK;
			end else if (reg_addr_i == `DCC_ADDR_BUF0) begin
				nxt_buf0 = reg_wdata_i;
			end else if (reg_addr_i == `DCC_ADDR_BUF1) begin
				nxt_buf1 = reg_wdata_i;
			end else if (reg_addr_i == `DCC_ADDR_CNT) begin
				nxt_cnt = reg_wdata_i[CNT_W-1:0];
			end
		end
		if (reg_rd_i) begin
			if (reg_addr_i == `DCC_ADDR_CTRL) begin
				nxt_rdata = ctrl_ff;
			end else if (reg_addr_i == `DCC_ADDR_STAT) begin
				nxt_rdata = stat_word;
			end else if (reg_addr_i == `DCC_ADDR_BUF0) begin
				nxt_rdata = buf0_ff;
			end else if (reg_addr_i == `DCC_ADDR_BUF1) begin
				nxt_rdata = buf1_ff;
			end else if (reg_addr_i == `DCC_ADDR_CNT) begin
				nxt_rdata = 16'(cnt_ff);
			end else begin
				nxt_rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_ff   <= `DCC_CTRL_RESET;
			buf0_ff   <= `DCC_BUF_RESET;
			buf1_ff   <= `DCC_BUF_RESET;
			cnt_ff    <= CNT_W'(`DCC_CNT_RESET);
			rdata_ff  <= 16'h0000;
			state_ff  <= dcc_pkg::DCC_ST_IDLE;
			pp_sel_ff <= 1'b0;
			idx_ff    <= '0;
			addr_ff   <= 16'h0000;
			done_ff   <= 1'b0;
			pulse_ff  <= 1'b0;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			buf0_ff   <= nxt_buf0;
			buf1_ff   <= nxt_buf1;
			cnt_ff    <= nxt_cnt;
			rdata_ff  <= nxt_rdata;
			state_ff  <= nxt_state;
			pp_sel_ff <= nxt_pp_sel;
			idx_ff    <= nxt_idx;
			addr_ff   <= nxt_addr;
			done_ff   <= nxt_done;
			pulse_ff  <= nxt_pulse;
		end
	end

	// ******************************
	// Output buffer
	// ******************************
	logic [$bits(dcc_pkg::dcc_xfer_t)-1:0] skid_out;

	dcc_skid #(
		.WIDTH($bits(dcc_pkg::dcc_xfer_t))
	) u_skid (
		.mclk_i      (mclk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (take),
		.in_ready_o  (skid_ready),
		.in_data_i   (push_word),
		.out_valid_o (xfer_valid_o),
		.out_ready_i (xfer_ready_i),
		.out_data_o  (skid_out)
	);

	always_comb begin
		xfer_o       = dcc_pkg::dcc_xfer_t'(skid_out);
		reg_rdata_o  = rdata_ff;
		active_o     = (state_ff == dcc_pkg::DCC_ST_RUN);
		block_done_o = pulse_ff;
	end

endmodule : dcc_channel

// ==== rtl/dcc_consts.svh ====
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// Register map
`define DCC_ADDR_CTRL       4'h0
`define DCC_ADDR_STAT       4'h1
`define DCC_ADDR_BUF0       4'h2
`define DCC_ADDR_BUF1       4'h3
`define DCC_ADDR_CNT        4'h4

// Control register fields
`define DCC_BIT_ON          15
`define DCC_BIT_SIZE        14
`define DCC_BIT_DIR         13
`define DCC_BIT_HALF        12
`define DCC_BIT_DUMMY       11
`define DCC_ADDRESSING_SELECT_HI        5
`define DCC_ADDRESSING_SELECT_LO        4
`define DCC_MODE_HI         1
`define DCC_MODE_LO         0
`define DCC_CTRL_WMASK      16'hf833
`define DCC_CTRL_RESET      16'h0000

// Status register fields
`define DCC_ST_BUSY         0
`define DCC_ST_PINGSEL      1
`define DCC_ST_DONE         2
`define DCC_ST_ADDRESSING_SELECT_ERR    3

`define DCC_CNT_RESET       16'h0000
`define DCC_BUF_RESET       16'h0000

`endif

// ==== rtl/dcc_pkg.sv ====
package dcc_pkg;

	typedef enum logic [1:0] {
		DCC_AM_POSTINC = 2'b00,
		DCC_AM_NOINC   = 2'b01,
		DCC_AM_PERIPH  = 2'b10,
		DCC_AM_RSVD    = 2'b11
	} dcc_addressing_select_t;

	typedef enum logic [1:0] {
		DCC_OM_CONT    = 2'b00,
		DCC_OM_ONESHOT = 2'b01,
		DCC_OM_CONT_PP = 2'b10,
		DCC_OM_ONE_PP  = 2'b11
	} dcc_opmode_t;

	// Gray order along idle -> run -> done
	typedef enum logic [1:0] {
		DCC_ST_IDLE = 2'b00,
		DCC_ST_RUN  = 2'b01,
		DCC_ST_DONE = 2'b11
	} dcc_state_t;

	typedef struct packed {
		logic [15:0] data;
		logic        byte_sz;
		logic        to_periph;
		logic [15:0] addr;
	} dcc_xfer_t;

endpackage : dcc_pkg

// ==== rtl/dcc_skid.sv ====
`timescale 1ns/1ps

module dcc_skid #(
	parameter int WIDTH = 34
) (
	input  wire logic             mclk_i,
	input  wire logic             resetn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	if (WIDTH < 1) begin : g_bad_width
		$error("dcc_skid: WIDTH must be positive");
	end

	logic [WIDTH-1:0] mem_ff [2];
	logic             wptr_ff, nxt_wptr;
	logic             rptr_ff, nxt_rptr;
	logic [1:0]       cnt_ff, nxt_cnt;
	logic             push, pop;

	// Two entries let a stall land one cycle late without dropping a word
	always_comb begin
		in_ready_o  = (cnt_ff != 2'd2);
		out_valid_o = (cnt_ff != 2'd0);
		out_data_o  = mem_ff[rptr_ff];
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		nxt_wptr    = push ? ~wptr_ff : wptr_ff;
		nxt_rptr    = pop ? ~rptr_ff : rptr_ff;
		nxt_cnt     = cnt_ff + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wptr_ff   <= 1'b0;
			rptr_ff   <= 1'b0;
			cnt_ff    <= 2'd0;
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff  <= nxt_cnt;
			if (push) begin
				mem_ff[wptr_ff] <= in_data_i;
			end
		end
	end

endmodule : dcc_skid
